// >>> pkg/bwp_pkg.sv
package bwp_pkg;
  // Host I/O decode, 10-bit port space
  localparam int IO_ADDR_W = 10;
  localparam logic [9:0] ID_ADDR = 10'h0E1;
  localparam logic [9:0] ID_ADDR_RELOC = 10'h1E1;
  localparam logic [9:0] MAP_ADDR = 10'h0E3;
  localparam logic [9:0] MAP_ADDR_RELOC = 10'h1E3;

  // Hold-off key
  localparam logic [7:0] HOLDOFF_KEY = 8'h5A;

  // Identification register fields
  localparam int PRODUCT_LSB = 3;
  localparam int THROTTLE_BIT = 2;
  localparam int REVISION_LSB = 0;

  // Map and paging control fields
  localparam int FLASH_EN_BIT = 7;
  localparam int WIN_SEL_LSB = 5;
  localparam int SYS_JUMPER_BIT = 4;
  localparam int VID_JUMPER_BIT = 3;
  localparam int PAGE_LSB = 0;
  localparam logic [7:0] MAP_WRITE_MASK = 8'hE7;
  localparam logic [7:0] MAP_RESET = 8'h00;

  // Window select encodings, bits 6:5
  localparam logic [1:0] WIN_NONE = 2'h0;
  localparam logic [1:0] WIN_SRAM_E000 = 2'h1;
  localparam logic [1:0] WIN_DISK_E000 = 2'h2;
  localparam logic [1:0] WIN_DISK_D800 = 2'h3;

  // Answer to an unmapped read
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Watchdog timing
  localparam int CLK_HZ = 50_000_000;
  localparam int WDOG_TIMEOUT_MS = 1000;
  localparam int WDOG_CYCLES = (WDOG_TIMEOUT_MS * (CLK_HZ / 1000));

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage

// >>> pkg/bwp_wdog_if.sv
`timescale 1ns/1ns
interface bwp_wdog_if;
  logic kick;
  logic reset_en;
  logic nmi_en;
  logic expired_rst;
  logic expired_nmi;
  logic expired;

  modport regs (output kick, output reset_en, output nmi_en,
                input expired_rst, input expired_nmi, input expired);
  modport wdog (input kick, input reset_en, input nmi_en,
                output expired_rst, output expired_nmi, output expired);
endinterface

// >>> hw/bwp_watchdog.sv
`timescale 1ns/1ns
module bwp_watchdog #(
  parameter int TIMEOUT_CYCLES = bwp_pkg::WDOG_CYCLES
) (
  input wire logic clk,     // System clock
  input wire logic rst,     // Synchronous reset, high
  bwp_wdog_if.wdog wd       // Kick, enables, expiry
);
  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

  initial begin
    if (TIMEOUT_CYCLES < 2) begin
      $error("bwp_watchdog: TIMEOUT_CYCLES must be at least 2");
    end
  end

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic exp_rst;
  logic next_exp_rst;
  logic exp_nmi;
  logic next_exp_nmi;
  logic exp_sticky;
  logic next_exp_sticky;
  logic armed;

  assign armed = wd.reset_en | wd.nmi_en;

  always_comb begin
    next_count = count;
    next_exp_rst = 1'b0;
    next_exp_nmi = 1'b0;
    next_exp_sticky = exp_sticky;
    if (!armed || wd.kick) begin
      // A kick restarts the full period
      next_count = '0;
    end else if (count == CW'(TIMEOUT_CYCLES - 1)) begin
      next_count = '0;
      next_exp_rst = wd.reset_en;
      next_exp_nmi = wd.nmi_en;
      next_exp_sticky = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
      exp_rst <= 1'b0;
      exp_nmi <= 1'b0;
      exp_sticky <= 1'b0;
    end else begin
      count <= next_count;
      exp_rst <= next_exp_rst;
      exp_nmi <= next_exp_nmi;
      exp_sticky <= next_exp_sticky;
    end
  end

  assign wd.expired_rst = exp_rst;
  assign wd.expired_nmi = exp_nmi;
  assign wd.expired = exp_sticky;
endmodule

// >>> hw/bwp_regs.sv
`timescale 1ns/1ns
// Summary of operation
// - The identification register is read at port 0xE1, or 0x1E1 when relocated.
// - Bits 7:3 of the identification register return a fixed, unwritable product code.
// - Bit 2 reports the throttling default caught at reset, one meaning 37.5 percent.
// - Bits 1:0 return the two-bit circuit revision code.
// - A write to the identification port goes to the watchdog hold-off port instead.
// - Writing 0x5A to the hold-off port restarts the watchdog period from zero.
// - On expiry the watchdog resets the processor and/or raises an NMI per its enables.
// - The map and paging register is read and written at port 0xE3, or 0x1E3 relocated.
// - Bit 7 opens the 64K flash window at E0000h; clear closes it.
// - While the flash window is open the page field picks the flash block shown.
// - Bits 6:5 pick none, SRAM at E000h, disk module at E000h, or disk module at D800h.
// - Bit 4 is read-only and shows the system firmware jumper.
// - The system firmware bit reads one with the jumper in, zero with it out.
// - Bit 3 is read-only and shows the video firmware jumper, one meaning jumper in.
// - Bits 2:0 pick one of eight consecutive 64K blocks of flash or SRAM.
module bwp_regs #(
  parameter logic [4:0] PRODUCT_CODE = 5'h1A,   // Arbitrary value
  parameter logic [1:0] CIRCUIT_REV = 2'h1,     // Arbitrary value
  parameter int WDOG_TIMEOUT_CYCLES = bwp_pkg::WDOG_CYCLES
) (
  input wire logic SYS_CLK,                 // System clock, 50 MHz
  input wire logic RST,                     // Synchronous reset, high
  input wire logic [9:0] IO_ADDR,           // Host I/O port address
  input wire logic IO_RD,                   // Read strobe, one cycle
  input wire logic IO_WR,                   // Write strobe, one cycle
  input wire logic [7:0] IO_WDATA,          // Write data
  input wire logic RELOCATE,                // Setup option: use 0x1Ex ports
  input wire logic SYS_FW_JUMPER,           // Pin: system firmware jumper in
  input wire logic VID_FW_JUMPER,           // Pin: video firmware jumper in
  input wire logic THROTTLE_STRAP,          // Pin: throttling default strap
  input wire logic WDOG_RESET_EN,           // Watchdog reset enable
  input wire logic WDOG_NMI_EN,             // Watchdog NMI enable
  output logic [7:0] IO_RDATA,              // Read data, held until next read
  output logic IO_RVALID,                   // Read data valid, one cycle
  output logic FLASH_WIN_EN,                // Flash window E0000h open
  output logic SRAM_WIN_EN,                 // SRAM window E000h open
  output logic DISK_WIN_HIGH_EN,            // Disk module window at E000h
  output logic DISK_WIN_LOW_EN,             // Disk module window at D800h
  output logic [2:0] PAGE_SELECT,           // 64K block mapped into window
  output logic CPU_RESET,                   // Watchdog reset, one cycle
  output logic NMI,                         // Watchdog NMI, one cycle
  output logic WDOG_EXPIRED                 // Watchdog has expired, sticky
);
  localparam int NPINS = 3;

  initial begin
    if (WDOG_TIMEOUT_CYCLES < 2) begin
      $error("bwp_regs: WDOG_TIMEOUT_CYCLES must be at least 2");
    end
  end

  bwp_wdog_if wd_if ();

  // Pin synchronisers: jumpers and throttle strap
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_s1;
  logic [NPINS-1:0] pin_s2;
  logic [NPINS-1:0] pin_s3;
  logic [NPINS-1:0] pin_stable;
  logic [NPINS-1:0] next_pin_stable;

  assign pin_raw = {THROTTLE_STRAP, VID_FW_JUMPER, SYS_FW_JUMPER};

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      // Change accepted only when stages two and three agree
      always_comb begin
        next_pin_stable[gi] = pin_stable[gi];
        if (pin_s2[gi] == pin_s3[gi]) begin
          next_pin_stable[gi] = pin_s3[gi];
        end
      end

      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_stable[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          pin_stable[gi] <= next_pin_stable[gi];
        end
      end
    end
  endgenerate

  // Throttle default caught once after reset, once the pipe has settled
  // Agreed value exists only from the fourth edge after release
  logic throttle_dflt;
  logic next_throttle_dflt;
  logic [2:0] settle;
  logic [2:0] next_settle;

  always_comb begin
    next_throttle_dflt = throttle_dflt;
    next_settle = settle;
    if (settle != 3'h5) begin
      next_settle = settle + 3'h1;
      if (settle == 3'h4) begin
        next_throttle_dflt = pin_stable[2];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      throttle_dflt <= 1'b0;
      settle <= 3'h0;
    end else begin
      throttle_dflt <= next_throttle_dflt;
      settle <= next_settle;
    end
  end

  // Address decode
  logic hit_id;
  logic hit_map;

  always_comb begin
    hit_id = (IO_ADDR == (RELOCATE ? bwp_pkg::ID_ADDR_RELOC : bwp_pkg::ID_ADDR));
    hit_map = (IO_ADDR == (RELOCATE ? bwp_pkg::MAP_ADDR_RELOC : bwp_pkg::MAP_ADDR));
  end

  // Readable images
  logic [7:0] id_image;
  logic [7:0] map_image;
  logic [7:0] map_ctrl;

  always_comb begin
    id_image = '0;
    id_image[bwp_pkg::PRODUCT_LSB +: 5] = PRODUCT_CODE;
    id_image[bwp_pkg::THROTTLE_BIT] = throttle_dflt;
    id_image[bwp_pkg::REVISION_LSB +: 2] = CIRCUIT_REV;
    map_image = map_ctrl & bwp_pkg::MAP_WRITE_MASK;
    map_image[bwp_pkg::SYS_JUMPER_BIT] = pin_stable[0];
    map_image[bwp_pkg::VID_JUMPER_BIT] = pin_stable[1];
  end

  // Map register, window decode and read port
  logic [7:0] next_map_ctrl;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_flash;
  logic next_sram;
  logic next_disk_hi;
  logic next_disk_lo;
  logic [2:0] next_page;
  logic next_kick;
  logic kick;
  logic [1:0] win_sel;

  always_comb begin
    next_map_ctrl = map_ctrl;
    next_rdata = IO_RDATA;
    next_rvalid = 1'b0;
    next_kick = 1'b0;
    if (IO_WR && hit_map) begin
      // Jumper bits are not storable
      next_map_ctrl = IO_WDATA & bwp_pkg::MAP_WRITE_MASK;
    end
    if (IO_WR && hit_id && IO_WDATA == bwp_pkg::HOLDOFF_KEY) begin
      next_kick = 1'b1;
    end
    if (IO_RD) begin
      next_rvalid = 1'b1;
      if (hit_id) begin
        next_rdata = id_image;
      end else if (hit_map) begin
        next_rdata = map_image;
      end else begin
        next_rdata = bwp_pkg::UNMAPPED_DATA;
      end
    end
    win_sel = next_map_ctrl[bwp_pkg::WIN_SEL_LSB +: 2];
    next_flash = next_map_ctrl[bwp_pkg::FLASH_EN_BIT];
    next_sram = (win_sel == bwp_pkg::WIN_SRAM_E000);
    next_disk_hi = (win_sel == bwp_pkg::WIN_DISK_E000);
    next_disk_lo = (win_sel == bwp_pkg::WIN_DISK_D800);
    next_page = next_map_ctrl[bwp_pkg::PAGE_LSB +: 3];
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      map_ctrl <= bwp_pkg::MAP_RESET;
      IO_RDATA <= bwp_pkg::RDATA_RESET;
      IO_RVALID <= 1'b0;
      FLASH_WIN_EN <= 1'b0;
      SRAM_WIN_EN <= 1'b0;
      DISK_WIN_HIGH_EN <= 1'b0;
      DISK_WIN_LOW_EN <= 1'b0;
      PAGE_SELECT <= 3'h0;
      kick <= 1'b0;
    end else begin
      map_ctrl <= next_map_ctrl;
      IO_RDATA <= next_rdata;
      IO_RVALID <= next_rvalid;
      FLASH_WIN_EN <= next_flash;
      SRAM_WIN_EN <= next_sram;
      DISK_WIN_HIGH_EN <= next_disk_hi;
      DISK_WIN_LOW_EN <= next_disk_lo;
      PAGE_SELECT <= next_page;
      kick <= next_kick;
    end
  end

  // Watchdog: enables come from the special control register outside
  assign wd_if.kick = kick;
  assign wd_if.reset_en = WDOG_RESET_EN;
  assign wd_if.nmi_en = WDOG_NMI_EN;

  bwp_watchdog #(
    .TIMEOUT_CYCLES(WDOG_TIMEOUT_CYCLES)
  ) u_wdog (
    .clk(SYS_CLK),
    .rst(RST),
    .wd(wd_if.wdog)
  );

  // Expiry outputs are flops inside the watchdog
  assign CPU_RESET = wd_if.expired_rst;
  assign NMI = wd_if.expired_nmi;
  assign WDOG_EXPIRED = wd_if.expired;
endmodule

// >>> test/bwp_regs_assertions.sv
`timescale 1ns/1ns
module bwp_regs_assertions #(
  parameter logic [4:0] PRODUCT_CODE = 5'h1A,
  parameter logic [1:0] CIRCUIT_REV = 2'h1
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [9:0] IO_ADDR,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic [7:0] IO_WDATA,
  input wire logic RELOCATE,
  input wire logic WDOG_RESET_EN,
  input wire logic WDOG_NMI_EN,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_RVALID,
  input wire logic FLASH_WIN_EN,
  input wire logic SRAM_WIN_EN,
  input wire logic DISK_WIN_HIGH_EN,
  input wire logic DISK_WIN_LOW_EN,
  input wire logic [2:0] PAGE_SELECT,
  input wire logic CPU_RESET,
  input wire logic NMI,
  input wire logic WDOG_EXPIRED
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic id_hit;
  logic map_hit;
  logic [3:0] win;
  assign id_hit = IO_ADDR == (RELOCATE ? bwp_pkg::ID_ADDR_RELOC : bwp_pkg::ID_ADDR);
  assign map_hit = IO_ADDR == (RELOCATE ? bwp_pkg::MAP_ADDR_RELOC : bwp_pkg::MAP_ADDR);
  assign win = {FLASH_WIN_EN, SRAM_WIN_EN, DISK_WIN_HIGH_EN, DISK_WIN_LOW_EN};
  AST_RD_ANSWER: assert property (IO_RD |=> IO_RVALID)
    else $error("read not answered");
  AST_RD_QUIET: assert property (!IO_RD |=> !IO_RVALID)
    else $error("read valid without read");
  AST_ID_FIELDS: assert property (IO_RD && id_hit |=>
    IO_RDATA[7:3] == PRODUCT_CODE && IO_RDATA[1:0] == CIRCUIT_REV) else $error("id fields");
  AST_MAP_WRITE: assert property (IO_WR && map_hit |=>
    {FLASH_WIN_EN, PAGE_SELECT} == {$past(IO_WDATA[7]), $past(IO_WDATA[2:0])})
    else $error("flash or page not written");
  AST_WIN_DECODE: assert property (IO_WR && map_hit |=> win[2:0] ==
    {$past(IO_WDATA[6:5]) == 2'h1, $past(IO_WDATA[6:5]) == 2'h2, $past(IO_WDATA[6:5]) == 2'h3})
    else $error("window decode");
  AST_WIN_HOLD: assert property (!(IO_WR && map_hit) |=> $stable({win, PAGE_SELECT}))
    else $error("windows moved without paging write");
  AST_RESET_CLOSES: assert property (disable iff (1'b0) RST |=>
    win == 4'h0 && PAGE_SELECT == 3'h0 && !WDOG_EXPIRED && !CPU_RESET && !NMI)
    else $error("outputs not cleared by reset");
  AST_EXPIRY_ENABLES: assert property ((CPU_RESET || NMI) |->
    (!CPU_RESET || $past(WDOG_RESET_EN)) && (!NMI || $past(WDOG_NMI_EN)))
    else $error("expiry action without enable");
  AST_EXPIRY_PULSE: assert property ((CPU_RESET || NMI) |=> !CPU_RESET && !NMI)
    else $error("expiry pulse too long");
  AST_EXPIRED_STICKY: assert property (WDOG_EXPIRED |=> WDOG_EXPIRED)
    else $error("expired flag dropped");
  // Holds only for timeouts of 9 cycles or more
  AST_KICK_RESTART: assert property (IO_WR && id_hit && IO_WDATA == bwp_pkg::HOLDOFF_KEY |->
    ##3 (!CPU_RESET && !NMI) [*8]) else $error("expiry right after key write");
  cover property (IO_RD && id_hit);
  cover property (IO_WR && map_hit);
  cover property (CPU_RESET);
  cover property (NMI);
endmodule
bind bwp_regs bwp_regs_assertions #(.PRODUCT_CODE(PRODUCT_CODE), .CIRCUIT_REV(CIRCUIT_REV))
  u_bwp_regs_assertions (.SYS_CLK(SYS_CLK), .RST(RST), .IO_ADDR(IO_ADDR), .IO_RD(IO_RD),
  .IO_WR(IO_WR), .IO_WDATA(IO_WDATA), .RELOCATE(RELOCATE), .WDOG_RESET_EN(WDOG_RESET_EN),
  .WDOG_NMI_EN(WDOG_NMI_EN), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
  .FLASH_WIN_EN(FLASH_WIN_EN), .SRAM_WIN_EN(SRAM_WIN_EN), .DISK_WIN_HIGH_EN(DISK_WIN_HIGH_EN),
  .DISK_WIN_LOW_EN(DISK_WIN_LOW_EN), .PAGE_SELECT(PAGE_SELECT), .CPU_RESET(CPU_RESET),
  .NMI(NMI), .WDOG_EXPIRED(WDOG_EXPIRED));

// >>> test/bwp_host_model.sv
`timescale 1ns/1ns
module bwp_host_model (
  input wire logic SYS_CLK,     // System clock
  output logic [9:0] IO_ADDR,   // Port address
  output logic IO_RD,           // Read strobe
  output logic IO_WR,           // Write strobe
  output logic [7:0] IO_WDATA,  // Write data
  input wire logic [7:0] IO_RDATA, // Read data
  input wire logic IO_RVALID    // Read data valid
);
  initial begin
    IO_ADDR = 10'h000;
    IO_RD = 1'b0;
    IO_WR = 1'b0;
    IO_WDATA = 8'h00;
  end
  // Idle bus shows the inverse, so a stale value never passes
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge SYS_CLK);
    IO_ADDR = a;
    IO_WDATA = d;
    IO_WR = 1'b1;
    @(negedge SYS_CLK);
    IO_WR = 1'b0;
    IO_ADDR = ~a;
    IO_WDATA = ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge SYS_CLK);
    IO_ADDR = a;
    IO_RD = 1'b1;
    @(negedge SYS_CLK);
    // Valid stands for one cycle only: take it before the next edge
    d = (IO_RVALID === 1'b1) ? IO_RDATA : 8'hXX;
    IO_RD = 1'b0;
    IO_ADDR = ~a;
  endtask
  // Must come faster than the expiry period
  task automatic kick();
    wr(10'h0E1, 8'h5A);
  endtask
endmodule

// >>> test/bwp_regs_test.sv
`timescale 1ns/1ns
module bwp_regs_test;
  typedef struct packed {logic reloc; logic [7:0] wdata; logic [3:0] win;} bwp_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reloc = 1'b0;
  logic sys_jmp = 1'b1;
  logic vid_jmp = 1'b0;
  logic strap = 1'b1;
  logic rst_en = 1'b0;
  logic nmi_en = 1'b0;
  logic [9:0] io_addr;
  logic io_rd, io_wr, io_rvalid, flash, sram, disk_hi, disk_lo, cpu_rst, nmi, expired;
  logic [7:0] io_wdata, io_rdata, d;
  logic [2:0] page;
  localparam int WDOG_N = 16;
  int n_errors = 0;
  int num_checks = 0;
  int n_pulse = 0;
  int i;
  bwp_row_t rows [6] = '{'{1'b0, 8'h00, 4'h0}, '{1'b0, 8'hA5, 4'hC}, '{1'b0, 8'h5A, 4'h2},
    '{1'b0, 8'h7F, 4'h1}, '{1'b1, 8'hE3, 4'h9}, '{1'b1, 8'h9C, 4'h8}};
  always #10 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (cpu_rst === 1'b1) n_pulse++;
  // Product code is arbitrary; short timeout keeps the run brief
  bwp_regs #(.PRODUCT_CODE(5'h0C), .CIRCUIT_REV(2'h0), .WDOG_TIMEOUT_CYCLES(WDOG_N)) u_bwp_regs (
    .SYS_CLK(sys_clk), .RST(rst), .IO_ADDR(io_addr), .IO_RD(io_rd), .IO_WR(io_wr),
    .IO_WDATA(io_wdata), .RELOCATE(reloc), .SYS_FW_JUMPER(sys_jmp), .VID_FW_JUMPER(vid_jmp),
    .THROTTLE_STRAP(strap), .WDOG_RESET_EN(rst_en), .WDOG_NMI_EN(nmi_en),
    .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid), .FLASH_WIN_EN(flash), .SRAM_WIN_EN(sram),
    .DISK_WIN_HIGH_EN(disk_hi), .DISK_WIN_LOW_EN(disk_lo), .PAGE_SELECT(page),
    .CPU_RESET(cpu_rst), .NMI(nmi), .WDOG_EXPIRED(expired));
  bwp_host_model u_bwp_host_model (.SYS_CLK(sys_clk), .IO_ADDR(io_addr), .IO_RD(io_rd),
    .IO_WR(io_wr), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid));
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wait_pulse();
    i = 0;
    while (cpu_rst !== 1'b1 && nmi !== 1'b1 && i < 40) begin
      @(negedge sys_clk);
      i++;
    end
  endtask
  task results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #60000;
    n_errors++;
    results();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("win_reset", {flash, sram, disk_hi, disk_lo, 1'b0, page}, 8'h00);
    u_bwp_host_model.rd(10'h0E3, d);
    chk("map_reset", d, 8'h10);
    for (int r = 0; r < 6; r++) begin
      reloc = rows[r].reloc;
      u_bwp_host_model.wr(reloc ? 10'h1E3 : 10'h0E3, rows[r].wdata);
      chk("win", {flash, sram, disk_hi, disk_lo, 1'b0, page},
        {rows[r].win, 1'b0, rows[r].wdata[2:0]});
      u_bwp_host_model.rd(reloc ? 10'h1E3 : 10'h0E3, d);
      chk("map", d, (rows[r].wdata & 8'hE7) | 8'h10);
      u_bwp_host_model.rd(reloc ? 10'h1E1 : 10'h0E1, d);
      chk("id", d, 8'h64);
    end
    reloc = 1'b0;
    u_bwp_host_model.wr(10'h0E1, 8'hFF);
    u_bwp_host_model.wr(10'h1E3, 8'hFF);
    u_bwp_host_model.rd(10'h0E3, d);
    chk("map_keep", d, 8'h94);
    u_bwp_host_model.rd(10'h0E1, d);
    chk("id_keep", d, 8'h64);
    u_bwp_host_model.rd(10'h1E3, d);
    chk("unmapped", d, 8'h00);
    sys_jmp = 1'b0;
    vid_jmp = 1'b1;
    repeat (8) @(negedge sys_clk);
    u_bwp_host_model.rd(10'h0E3, d);
    chk("jumpers", d, 8'h8C);
    rst_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      u_bwp_host_model.kick();
      repeat (8) @(negedge sys_clk);
    end
    chk("no_expiry", 8'(n_pulse), 8'h00);
    wait_pulse();
    // Counted from the end of the last key write; the kick flop adds one cycle
    chk("expiry_delay", 8'(i + 8), 8'(WDOG_N + 1));
    chk("reset_action", {cpu_rst, nmi, expired}, 8'h05);
    rst_en = 1'b0;
    nmi_en = 1'b1;
    @(negedge sys_clk);
    wait_pulse();
    chk("nmi_action", {cpu_rst, nmi, expired}, 8'h03);
    nmi_en = 1'b0;
    strap = 1'b0;
    rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("expired_clear", {expired, flash, page}, 8'h00);
    u_bwp_host_model.rd(10'h0E1, d);
    chk("id_throttle", d, 8'h60);
    results();
  end
endmodule
